/* hdl/tmx_pkg.sv */
// Summary of operation
// [R1] Payload write starts serial send when enabled
// [R2] Select field picks test pair, pads enabled
// [R3] Codes zero to four pick internal pairs
// [R4] Codes five to nine pick internal pairs
// [R5] Code ten drives static test bits
// [R6] Codes eleven to fifteen undefined, drive zero
// [R7] Prescale bit divides reference clock by four
// [R8] Serial enable routes data, clock, enable pins
// [R9] Read-only lock bit, reset zero
// [R10] Separate bit gates lock flag onto pin
// [R11] Frame enable held, ten bits MSB first
package tmx_pkg;
    // Register word offsets; byte address is four times the index.
    localparam logic [7:0] TMX_IDX_PAYLOAD = 8'h0c;
    localparam logic [7:0] TMX_IDX_SELECT = 8'h0d;
    localparam logic [7:0] TMX_IDX_LOCK = 8'h0f;
    localparam logic [7:0] TMX_IDX_CTRL = 8'h10;
    localparam logic [7:0] TMX_IDX_IRQ_STAT = 8'h11;
    localparam logic [7:0] TMX_IDX_IRQ_EN = 8'h12;
    localparam logic [7:0] TMX_IDX_IRQ_CLR = 8'h13;
    // Widths and reset values.
    localparam int TMX_PAYLOAD_W = 10;
    localparam logic [9:0] TMX_PAYLOAD_RST = 10'h001;
    localparam logic [3:0] TMX_SEL_RST = 4'ha;
    localparam logic [3:0] TMX_SEL_STATIC = 4'ha;
    localparam logic [1:0] TMX_PRESCALE_DIV = 2'h3;
    // Select register field positions.
    localparam int TMX_F_STATIC_LO = 4;
    localparam int TMX_F_PRESCALE = 6;
    localparam int TMX_F_SER_EN = 7;
    // Control register field positions (pad enable, lock flag pin enable).
    localparam int TMX_F_PADS_EN = 0;
    localparam int TMX_F_LD_PIN_EN = 1;
    localparam logic [1:0] TMX_CTRL_RST = 2'h2;
    // Interrupt events: bit 0 frame done, bit 1 lock gained, bit 2 lock lost.
    localparam int TMX_IRQ_W = 3;

    // Internal test signals, one struct carries all candidates.
    typedef struct packed {
        logic clk_vcodiv;
        logic clk_refdiv;
        logic pfd_up;
        logic pfd_dn;
        logic ref_out;
        logic ref_div_out;
        logic seed_stb;
        logic frac_stb;
        logic intg_buf_en;
        logic clk_sd;
        logic oneshot_trig;
        logic oneshot_pulse;
        logic ring_osc;
        logic csp_add;
        logic csp_sub;
        logic sat_refdiv;
        logic sat_vcodiv;
        logic sat_rst;
    } tmx_test_sig_t;

    // Pin triple of the serial and test outputs.
    typedef struct packed {
        logic lock_or_serial_out_pin;
        logic pin1;
        logic pin0;
    } tmx_pins_t;
endpackage

/* hdl/tmx_top.sv */
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
// Test multiplexer, lock flag and auxiliary serial port for the external oscillator.
module tmx_top #(
    parameter int PAYLOAD_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic ref_clk_i,
    input wire logic locked_i,
    input wire tmx_pkg::tmx_test_sig_t test_sig_i,
    output logic lock_or_serial_out_pin_o,
    output logic test_out_pin0_o,
    output logic test_out_pin1_o,
    output logic irq_o
);
    import tmx_pkg::*;

    // Serial engine states.
    typedef enum logic [1:0] {
        TMX_IDLE,
        TMX_SHIFT,
        TMX_DONE
    } tmx_state_t;

    // Register state.
    logic [PAYLOAD_W-1:0] payload_r, payload_nxt;
    logic [7:0] select_r, select_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [TMX_IRQ_W-1:0] stat_r, stat_nxt;
    logic [TMX_IRQ_W-1:0] irq_en_r, irq_en_nxt;
    logic ack_r, ack_nxt;
    logic err_r, err_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // Serial engine state.
    tmx_state_t state_r, state_nxt;
    logic [PAYLOAD_W-1:0] shift_r, shift_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic sclk_r, sclk_nxt;
    logic start_r, start_nxt;
    // Synchronisers and prescaler.
    logic ref_s1_r, ref_s2_r, ref_s3_r;
    logic lock_s1_r, lock_s2_r, lock_d_r;
    logic [1:0] pre_cnt_r, pre_cnt_nxt;
    logic tick;
    // Pin outputs.
    tmx_pins_t pins_r, pins_nxt;
    logic irq_r, irq_nxt;

    // Request decode; the word index drops the two byte bits.
    logic req;
    logic [7:0] idx;
    logic wr;
    assign req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign idx = wb_adr_i[9:2];
    assign wr = req & wb_we_i;

    // Reference and lock pins come from other domains, so two flops first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
            lock_d_r <= 1'b0;
        end else begin
            ref_s1_r <= ref_clk_i;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
            lock_s1_r <= locked_i;
            lock_s2_r <= lock_s1_r;
            lock_d_r <= lock_s2_r;
        end
    end

    // A rising reference edge counts; the prescaler passes every fourth when set.
    always_comb begin
        logic ref_rise;
        ref_rise = ref_s2_r & ~ref_s3_r;
        pre_cnt_nxt = pre_cnt_r;
        tick = 1'b0;
        if (ref_rise) begin
            if (select_r[TMX_F_PRESCALE]) begin // R7
                pre_cnt_nxt = pre_cnt_r + 2'h1;
                tick = (pre_cnt_r == TMX_PRESCALE_DIV);
            end else begin
                pre_cnt_nxt = 2'h0;
                tick = 1'b1;
            end
        end
    end

    // Register file next state, with bus handshake.
    always_comb begin
        logic hit;
        hit = 1'b1;
        payload_nxt = payload_r;
        select_nxt = select_r;
        ctrl_nxt = ctrl_r;
        irq_en_nxt = irq_en_r;
        rdata_nxt = rdata_r;
        start_nxt = 1'b0;
        unique case (idx)
            TMX_IDX_PAYLOAD: rdata_nxt = 32'(payload_r);
            TMX_IDX_SELECT: rdata_nxt = 32'(select_r);
            TMX_IDX_LOCK: rdata_nxt = 32'(lock_d_r); // R9
            TMX_IDX_CTRL: rdata_nxt = 32'(ctrl_r);
            TMX_IDX_IRQ_STAT: rdata_nxt = 32'(stat_r);
            TMX_IDX_IRQ_EN: rdata_nxt = 32'(irq_en_r);
            TMX_IDX_IRQ_CLR: rdata_nxt = 32'h0;
            default: hit = 1'b0;
        endcase
        if (wr && hit) begin
            unique case (idx)
                TMX_IDX_PAYLOAD: begin
                    if (wb_sel_i[0]) begin
                        payload_nxt[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        payload_nxt[PAYLOAD_W-1:8] = wb_dat_i[PAYLOAD_W-1:8];
                    end
                    start_nxt = 1'b1; // R1
                end
                TMX_IDX_SELECT: begin
                    if (wb_sel_i[0]) begin
                        select_nxt = wb_dat_i[7:0];
                    end
                end
                TMX_IDX_CTRL: begin
                    if (wb_sel_i[0]) begin
                        ctrl_nxt = wb_dat_i[1:0];
                    end
                end
                TMX_IDX_IRQ_EN: begin
                    if (wb_sel_i[0]) begin
                        irq_en_nxt = wb_dat_i[TMX_IRQ_W-1:0];
                    end
                end
                default: begin
                    // Read-only and clear registers store nothing here.
                end
            endcase
        end
        ack_nxt = req & hit;
        err_nxt = req & ~hit;
    end

    // Serial engine: one bit per two ticks, clock high in mid bit, enable over the frame.
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        sclk_nxt = sclk_r;
        unique case (state_r)
            TMX_IDLE: begin
                sclk_nxt = 1'b0;
                if (start_r && select_r[TMX_F_SER_EN]) begin // R1
                    shift_nxt = payload_r;
                    bit_cnt_nxt = 4'h0;
                    state_nxt = TMX_SHIFT;
                end
            end
            TMX_SHIFT: begin
                if (tick) begin
                    if (!sclk_r) begin
                        sclk_nxt = 1'b1;
                    end else begin
                        sclk_nxt = 1'b0;
                        shift_nxt = {shift_r[PAYLOAD_W-2:0], 1'b0}; // R11
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'(PAYLOAD_W - 1)) begin
                            state_nxt = TMX_DONE;
                        end
                    end
                end
            end
            TMX_DONE: state_nxt = TMX_IDLE;
            default: state_nxt = TMX_IDLE;
        endcase
    end

    // Pin mux: serial takes priority, else test pair on pins 1 and 0 and lock flag on the third pin.
    always_comb begin
        logic [1:0] pair;
        pair = 2'b00;
        unique case (select_r[3:0]) // R2
            4'h0: pair = {test_sig_i.clk_vcodiv, test_sig_i.clk_refdiv}; // R3
            4'h1: pair = {test_sig_i.pfd_up, test_sig_i.pfd_dn};
            4'h2: pair = {test_sig_i.ref_out, test_sig_i.ref_div_out};
            4'h3: pair = {test_sig_i.seed_stb, test_sig_i.frac_stb};
            4'h4: pair = {test_sig_i.intg_buf_en, test_sig_i.clk_sd};
            4'h5: pair = {test_sig_i.oneshot_trig, test_sig_i.oneshot_pulse}; // R4
            4'h6: pair = {1'b0, test_sig_i.ring_osc};
            4'h7: pair = {test_sig_i.csp_add, test_sig_i.csp_sub};
            4'h8: pair = {test_sig_i.sat_refdiv, test_sig_i.sat_vcodiv};
            4'h9: pair = {test_sig_i.csp_add | test_sig_i.csp_sub, test_sig_i.sat_rst};
            TMX_SEL_STATIC: begin
                pair = select_r[TMX_F_STATIC_LO+1:TMX_F_STATIC_LO]; // R5
            end
            default: pair = 2'b00; // R6
        endcase
        if (!ctrl_r[TMX_F_PADS_EN]) begin
            pair = 2'b00; // R2
        end
        pins_nxt.lock_or_serial_out_pin = ctrl_r[TMX_F_LD_PIN_EN] & lock_d_r; // R10
        pins_nxt.pin1 = pair[1];
        pins_nxt.pin0 = pair[0];
        if (select_r[TMX_F_SER_EN]) begin // R8
            pins_nxt.lock_or_serial_out_pin = (state_r == TMX_SHIFT) & shift_r[PAYLOAD_W-1];
            pins_nxt.pin1 = sclk_r;
            pins_nxt.pin0 = (state_r == TMX_SHIFT); // R11
        end
    end

    // Sticky events; set wins over a clear in the same cycle.
    always_comb begin
        logic [TMX_IRQ_W-1:0] ev;
        logic [TMX_IRQ_W-1:0] clr;
        ev = {lock_d_r & ~lock_s2_r, ~lock_d_r & lock_s2_r, state_r == TMX_DONE};
        clr = (wr && idx == TMX_IDX_IRQ_CLR && wb_sel_i[0]) ? wb_dat_i[TMX_IRQ_W-1:0]
                                                             : '0;
        stat_nxt = (stat_r & ~clr) | ev;
        irq_nxt = |(stat_nxt & irq_en_nxt);
    end

    // Registers only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            payload_r <= TMX_PAYLOAD_RST;
            select_r <= {4'h0, TMX_SEL_RST};
            ctrl_r <= TMX_CTRL_RST;
            stat_r <= '0;
            irq_en_r <= '0;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h0;
            state_r <= TMX_IDLE;
            shift_r <= '0;
            bit_cnt_r <= 4'h0;
            sclk_r <= 1'b0;
            start_r <= 1'b0;
            pre_cnt_r <= 2'h0;
            pins_r <= '0;
            irq_r <= 1'b0;
        end else begin
            payload_r <= payload_nxt;
            select_r <= select_nxt;
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            irq_en_r <= irq_en_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            rdata_r <= rdata_nxt;
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sclk_r <= sclk_nxt;
            start_r <= start_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            pins_r <= pins_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign wb_dat_o = rdata_r;
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign lock_or_serial_out_pin_o = pins_r.lock_or_serial_out_pin;
    assign test_out_pin1_o = pins_r.pin1;
    assign test_out_pin0_o = pins_r.pin0;
    assign irq_o = irq_r;

    // Reference edges seen since the last tick, counted apart from the prescaler.
    // The divide-by-four check reads this count, not the prescaler's own flops.
    // Otherwise it would agree with the divider by construction.
    logic [1:0] rise_seen_r, rise_seen_nxt; // Rises not yet turned into a tick.
    always_comb begin
        rise_seen_nxt = rise_seen_r;
        if (tick) begin
            rise_seen_nxt = 2'h0;
        end else if (ref_s2_r && !ref_s3_r) begin
            rise_seen_nxt = rise_seen_r + 2'h1;
        end
    end

    // Registers the check counter only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_seen_r <= 2'h0;
        end else begin
            rise_seen_r <= rise_seen_nxt;
        end
    end

    // Checks.
    a_write_starts_frame: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        (start_r && state_r == TMX_IDLE && select_r[TMX_F_SER_EN]) |=> state_r == TMX_SHIFT)
        else $error("payload write did not start a frame");
    a_static_bits_out: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (select_r[3:0] == TMX_SEL_STATIC && ctrl_r[TMX_F_PADS_EN] && !select_r[TMX_F_SER_EN]
         && $stable(select_r) && $stable(ctrl_r))
        |=> {test_out_pin1_o, test_out_pin0_o} == $past(select_r[5:4]))
        else $error("static test bits not on pins");
    a_undef_code_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        (select_r[3:0] > TMX_SEL_STATIC && !select_r[TMX_F_SER_EN]) |=> !test_out_pin0_o)
        else $error("undefined select drove a pin");
    a_pads_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (!ctrl_r[TMX_F_PADS_EN] && !select_r[TMX_F_SER_EN]) |=> !test_out_pin1_o)
        else $error("pads disabled but pin driven");
    a_div1_tick: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (ref_s2_r && !ref_s3_r && !select_r[TMX_F_PRESCALE]) |-> tick)
        else $error("undivided reference lost a tick");
    a_div4_skip: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (tick && select_r[TMX_F_PRESCALE]) |-> rise_seen_r == TMX_PRESCALE_DIV)
        else $error("divide by four ticked early");
    a_serial_enable_pin: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        select_r[TMX_F_SER_EN] && $stable(select_r) |=>
        test_out_pin0_o == ($past(state_r) == TMX_SHIFT))
        else $error("serial enable not on pin 0");
    a_lock_pin_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        (!select_r[TMX_F_SER_EN] && !ctrl_r[TMX_F_LD_PIN_EN] && $stable(select_r)) |=>
        !lock_or_serial_out_pin_o)
        else $error("lock flag leaked to pin");
    a_frame_length: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (state_r == TMX_SHIFT && tick && sclk_r) |-> bit_cnt_r < 4'(PAYLOAD_W))
        else $error("frame too long");
    a_lock_read: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        (req && !wb_we_i && idx == TMX_IDX_LOCK) |=> wb_dat_o == 32'($past(lock_d_r)))
        else $error("lock bit read wrong");
    c_frame_sent: cover property (@(posedge clk_i) disable iff (rst_i) state_r == TMX_DONE);
    c_static_mode: cover property (@(posedge clk_i) disable iff (rst_i)
        select_r[3:0] == TMX_SEL_STATIC && ctrl_r[TMX_F_PADS_EN]);
    c_lock_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o && stat_r[2]);
    c_div4_frame: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == TMX_DONE && select_r[TMX_F_PRESCALE]);
    // The interrupt line follows the enabled sticky bits with no extra delay.
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(stat_r & irq_en_r))
        else $error("interrupt line disagrees with enabled status");
    // A clear in the same cycle as the event must not swallow it.
    a_sticky_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == TMX_DONE) |=> stat_r[0])
        else $error("frame done event lost against a clear");
endmodule // tmx_top

/* testbench/tmx_top_tb.sv */
`timescale 1ns/1ns
// Register-level bench for the test multiplexer and auxiliary serial port.
module tmx_top_tb;
    import tmx_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic ref_clk_i = 1'b0;
    logic locked_i = 1'b0;
    tmx_test_sig_t test_sig_i = '0;
    logic ld_o, p0_o, p1_o, irq_o;
    logic [9:0] m_word;
    int m_frames, m_bits;
    int fail_count = 0;
    int n_tests = 0;
    int cyc_n = 0;
    int f, dur;
    int en_cyc = 0; // Free-running count of cycles with the serial enable pin high.
    logic [31:0] rd; // Read data taken at the ack edge.
    logic got_err; // Error answer seen at the answer edge.
    tmx_test_sig_t pat [4] = '{18'h2aaaa, 18'h15555, 18'h3ffff, 18'h00000};

    tmx_top #(.PAYLOAD_W(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .ref_clk_i(ref_clk_i), .locked_i(locked_i), .test_sig_i(test_sig_i),
        .lock_or_serial_out_pin_o(ld_o), .test_out_pin0_o(p0_o), .test_out_pin1_o(p1_o),
        .irq_o(irq_o));
    tmx_vco_model u_vco (.en_i(p0_o), .sclk_i(p1_o), .sdat_i(ld_o), .word_o(m_word),
        .frames_o(m_frames), .bits_o(m_bits));

    initial forever #4 clk_i = ~clk_i;
    // Reference rises every 8 cycles, safely under the clk/4 limit; also the hang guard.
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (p0_o === 1'b1) en_cyc <= en_cyc + 1;
        if (cyc_n % 4 == 3) ref_clk_i <= ~ref_clk_i;
        if (cyc_n == 30000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; ack or err is sampled at the edge that ends it.
    task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {22'h0, idx, 2'b00};
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            k++;
        end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && k < 50);
        rd = wb_dat_o;
        got_err = wb_err_o;
        if (k >= 50) chk("bus answer", 32'h0, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, idx, 32'h0);
        chk("register read", rd & m, e);
    endtask

    task automatic settle();
        repeat (5) @(posedge clk_i);
    endtask

    // Expected pin pair {pin1, pin0} for each select code; undefined codes give zero.
    function automatic logic [1:0] pair(input int c, input tmx_test_sig_t s);
        case (c)
            0: return {s.clk_vcodiv, s.clk_refdiv};
            1: return {s.pfd_up, s.pfd_dn};
            2: return {s.ref_out, s.ref_div_out};
            3: return {s.seed_stb, s.frac_stb};
            4: return {s.intg_buf_en, s.clk_sd};
            5: return {s.oneshot_trig, s.oneshot_pulse};
            6: return {1'b0, s.ring_osc};
            7: return {s.csp_add, s.csp_sub};
            8: return {s.sat_refdiv, s.sat_vcodiv};
            9: return {s.csp_add | s.csp_sub, s.sat_rst};
            default: return 2'b00;
        endcase
    endfunction

    // Waits for the model to close a frame; the enable time comes from the free count,
    // so the cycles spent inside a mid-frame write are not lost.
    task automatic wait_frame(input int f0, input logic poke);
        int e0;
        e0 = en_cyc;
        for (int k = 0; k < 4000 && m_frames == f0; k++) begin
            @(posedge clk_i);
            if (poke && k == 100) wb(1'b1, TMX_IDX_PAYLOAD, 32'h3c3);
        end
        dur = en_cyc - e0;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(TMX_IDX_PAYLOAD, 32'h3ff, 32'h001);
        rdchk(TMX_IDX_SELECT, 32'hf, 32'ha);
        rdchk(TMX_IDX_LOCK, 32'h1, 32'h0);
        wb(1'b0, 8'h3f, 32'h0);
        chk("unmapped error", {31'h0, got_err}, 32'h1);
        $display("test reset values done");
        // Every select code against four input patterns, code 10 against two; code 10 shows the static bits.
        wb(1'b1, TMX_IDX_CTRL, 32'h3);
        for (int c = 0; c < 16; c++) begin
            for (int p = 0; p < 4; p += (c == 10) ? 3 : 1) begin
                wb(1'b1, TMX_IDX_SELECT, {26'h0, 2'(p), 4'(c)});
                test_sig_i <= pat[p];
                settle();
                chk("test pins", {p1_o, p0_o}, (c == 10) ? 2'(p) : pair(c, pat[p]));
            end
        end
        wb(1'b1, TMX_IDX_CTRL, 32'h2);
        wb(1'b1, TMX_IDX_SELECT, 32'h0);
        settle();
        chk("pads off", {p1_o, p0_o}, 2'b00);
        $display("test multiplexer done");
        locked_i <= 1'b1;
        settle();
        rdchk(TMX_IDX_LOCK, 32'h1, 32'h1);
        chk("lock pin on", ld_o, 1'b1);
        wb(1'b1, TMX_IDX_CTRL, 32'h0);
        settle();
        chk("lock pin off", ld_o, 1'b0);
        $display("test lock flag done");
        // Payload write without serial enable must not send anything.
        test_sig_i <= '0;
        wb(1'b1, TMX_IDX_CTRL, 32'h3);
        wb(1'b1, TMX_IDX_IRQ_CLR, 32'h7);
        wb(1'b1, TMX_IDX_IRQ_EN, 32'h1);
        f = m_frames;
        wb(1'b1, TMX_IDX_PAYLOAD, 32'h155);
        repeat (300) @(posedge clk_i);
        chk("no frame", m_frames, f);
        chk("irq idle", irq_o, 1'b0);
        for (int pre = 0; pre < 2; pre++) begin
            wb(1'b1, TMX_IDX_SELECT, {24'h0, 1'b1, 1'(pre), 6'h0});
            settle();
            f = m_frames;
            wb(1'b1, TMX_IDX_PAYLOAD, pre ? 32'h14a : 32'h2b5);
            wait_frame(f, 1'(pre));
            repeat (400) @(posedge clk_i);
            chk("frame count", m_frames, f + 1);
            chk("frame word", m_word, pre ? 10'h14a : 10'h2b5);
            chk("frame bits", m_bits, 10);
            chk("frame length", (dur >= 152 * (1 + 3 * pre) && dur <= 176 * (1 + 3 * pre)), 1);
            if (pre == 0) begin
                chk("irq raised", irq_o, 1'b1);
                rdchk(TMX_IDX_IRQ_STAT, 32'h1, 32'h1);
                wb(1'b1, TMX_IDX_IRQ_EN, 32'h0);
                settle();
                chk("irq masked", irq_o, 1'b0);
                wb(1'b1, TMX_IDX_IRQ_EN, 32'h1);
                wb(1'b1, TMX_IDX_IRQ_CLR, 32'h1);
                settle();
                chk("irq cleared", irq_o, 1'b0);
            end
        end
        rdchk(TMX_IDX_PAYLOAD, 32'h3ff, 32'h3c3);
        $display("test serial port done");
        final_report();
    end
endmodule // tmx_top_tb

/* testbench/tmx_vco_model.sv */
`timescale 1ns/1ns
// Listener in place of the external oscillator's serial control port.
module tmx_vco_model (
    input wire logic en_i,
    input wire logic sclk_i,
    input wire logic sdat_i,
    output logic [9:0] word_o,
    output int frames_o,
    output int bits_o
);
    logic [9:0] shift_r; // Bits gathered so far in this frame.
    int cnt; // Serial clocks seen inside this frame.
    initial begin
        word_o = '0;
        frames_o = 0;
        bits_o = 0;
        shift_r = '0;
        cnt = 0;
    end
    // A new frame restarts the bit count, so a stray clock before it cannot leak in.
    always @(posedge en_i) begin
        cnt = 0;
    end
    // Take one bit on each rising serial clock while enabled, first bit is the MSB.
    always @(posedge sclk_i) begin
        if (en_i === 1'b1) begin
            shift_r = {shift_r[8:0], sdat_i};
            cnt = cnt + 1;
        end
    end
    // The frame closes on the falling enable; the bit count exposes short frames.
    always @(negedge en_i) begin
        word_o = shift_r;
        bits_o = cnt;
        frames_o = frames_o + 1;
    end
endmodule // tmx_vco_model
